// ---- logic/nvc_ctrl.sv ----
// Nested vectored interrupt controller: arbitration, stacking, vector fetch, return
// Overview of operation
// - Thirty-two request inputs 31..0 are taken, each given one of four priority levels.
// - Every request's priority comes from a software-set configuration value, not a fixed one.
// - A new request preempts the running handler only if its priority is strictly higher.
// - On acceptance the handler start address is read from the vector table in memory.
// - On entry the core's pc, status word, link register, r12 and r0-r3 are pushed to the stack.
// - When a handler ends the saved frame is popped and interrupted execution resumes.
// - A handler end with an eligible request pending chains straight to it with no pop or push.
// - A higher request arriving during push or before fetch takes over entry at no added cost.
// - Taking any interrupt places the core in handler mode, where all servicing happens.
// - An exception return is honoured only in handler mode and ignored in thread mode.
// - Reset leaves thread mode, which an exception return can enter again.
module nvc_ctrl
    import nvc_pkg::*;
(
    input  wire logic                               clk_i,
    input  wire logic                               rst_b_i,
    input  wire logic [NVC_NUM_IRQ-1:0]             irq_i,
    input  wire logic [NVC_NUM_IRQ*NVC_PRIO_W-1:0]  irq_prio_i,
    input  wire logic                               exc_return_i,
    input  wire logic [31:0]                        sp_i,
    input  wire logic [31:0]                        vec_base_i,
    input  wire logic [31:0]                        save_word_i,
    output logic      [2:0]                         save_sel_o,
    output logic                                    mem_req_o,
    output logic                                    mem_we_o,
    output logic      [31:0]                        mem_addr_o,
    output logic      [31:0]                        mem_wdata_o,
    input  wire logic                               mem_ack_i,
    input  wire logic [31:0]                        mem_rdata_i,
    output logic                                    rest_we_o,
    output logic      [2:0]                         rest_sel_o,
    output logic      [31:0]                        rest_data_o,
    output logic                                    sp_load_o,
    output logic      [31:0]                        sp_val_o,
    output logic                                    branch_o,
    output logic      [31:0]                        branch_addr_o,
    output logic      [5:0]                         exc_num_o,
    output logic                                    resume_o,
    output logic                                    core_hold_o,
    output logic                                    handler_mode_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    nvc_state_t                      state_q,    state_d;
    logic [NVC_NUM_IRQ-1:0]          pend_q,     pend_d;
    logic [NVC_NUM_LVL-1:0]          lvl_act_q,  lvl_act_d;
    logic [31:0]                     addr_q,     addr_d;
    logic                            mode_q,     mode_d;
    logic [NVC_IRQ_W-1:0]            tgt_q,      tgt_d;
    logic [2:0]                      cnt_q,      cnt_d;
    logic [31:0]                     frame_q,    frame_d;
    logic                            sp_load_q,  sp_load_d;
    logic [31:0]                     sp_val_q,   sp_val_d;
    logic                            branch_q,   branch_d;
    logic [31:0]                     baddr_q,    baddr_d;
    logic [5:0]                      exc_q,      exc_d;
    logic                            resume_q,   resume_d;

    logic [NVC_PRIO_W-1:0]           prio     [NVC_NUM_IRQ];
    logic [NVC_IRQ_W-1:0]            best_idx;
    logic [NVC_LVL_W-1:0]            best_lvl;
    logic [NVC_LVL_W-1:0]            run_lvl;
    logic [NVC_LVL_W-1:0]            ret_lvl;
    logic [NVC_NUM_LVL-1:0]          act_after_ret;
    logic [NVC_NUM_IRQ-1:0]          clr_pend;
    logic                            take_ok;
    logic                            ret_ok;
    logic                            chain_ok;
    logic                            push_done;
    logic                            fetch_done;
    logic                            pop_done;

    // ------------------------------------------------------------
    // Priority fields per input
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NVC_NUM_IRQ; gi++) begin : g_prio
            assign prio[gi] = irq_prio_i[gi*NVC_PRIO_W +: NVC_PRIO_W];
        end
    endgenerate

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    always_comb begin
        best_idx = '0;
        best_lvl = NVC_LVL_THREAD;
        // Strict less-than keeps the lowest number among equals
        for (int i = 0; i < NVC_NUM_IRQ; i++) begin
            if (pend_q[i] && ({1'b0, prio[i]} < best_lvl)) begin
                best_lvl = {1'b0, prio[i]};
                best_idx = NVC_IRQ_W'(i);
            end
        end
    end

    // Running level is the highest active one, thread level when none
    always_comb begin
        run_lvl = NVC_LVL_THREAD;
        for (int l = NVC_NUM_LVL - 1; l >= 0; l--) begin
            if (lvl_act_q[l]) begin
                run_lvl = NVC_LVL_W'(l);
            end
        end
    end

    // Level left running once the current handler retires
    always_comb begin
        act_after_ret = lvl_act_q;
        if (run_lvl != NVC_LVL_THREAD) begin
            act_after_ret[run_lvl[1:0]] = 1'b0;
        end
        ret_lvl = NVC_LVL_THREAD;
        for (int l = NVC_NUM_LVL - 1; l >= 0; l--) begin
            if (act_after_ret[l]) begin
                ret_lvl = NVC_LVL_W'(l);
            end
        end
    end

    assign take_ok  = best_lvl < run_lvl;
    assign ret_ok   = exc_return_i && (run_lvl != NVC_LVL_THREAD);
    assign chain_ok = best_lvl < ret_lvl;
    assign push_done  = (state_q == NVC_ST_PUSH) && mem_ack_i && (cnt_q == NVC_LAST_WORD);
    assign fetch_done = (state_q == NVC_ST_FETCH) && mem_ack_i;
    assign pop_done   = (state_q == NVC_ST_POP) && mem_ack_i && (cnt_q == NVC_LAST_WORD);

    // ------------------------------------------------------------
    // Control next state
    // ------------------------------------------------------------
    always_comb begin
        state_d   = state_q;
        lvl_act_d = lvl_act_q;
        tgt_d     = tgt_q;
        cnt_d     = cnt_q;
        frame_d   = frame_q;
        clr_pend  = '0;
        unique case (state_q)
            NVC_ST_IDLE: begin
                if (ret_ok) begin
                    lvl_act_d = act_after_ret;
                    if (chain_ok) begin
                        tgt_d   = best_idx;
                        state_d = NVC_ST_FETCH;
                    end else begin
                        frame_d = sp_i;
                        cnt_d   = '0;
                        state_d = NVC_ST_POP;
                    end
                end else if (take_ok) begin
                    tgt_d   = best_idx;
                    frame_d = sp_i - NVC_FRAME_BYTES;
                    cnt_d   = '0;
                    state_d = NVC_ST_PUSH;
                end
            end
            NVC_ST_PUSH: begin
                // Best pending can only improve, so follow it to the fetch
                tgt_d = best_idx;
                if (mem_ack_i) begin
                    cnt_d = cnt_q + 3'h1;
                    if (push_done) begin
                        state_d = NVC_ST_FETCH;
                    end
                end
            end
            NVC_ST_FETCH: begin
                if (mem_ack_i) begin
                    lvl_act_d[prio[tgt_q]] = 1'b1;
                    clr_pend[tgt_q]        = 1'b1;
                    state_d                = NVC_ST_IDLE;
                end
            end
            NVC_ST_POP: begin
                if (mem_ack_i) begin
                    cnt_d = cnt_q + 3'h1;
                    if (pop_done) begin
                        state_d = NVC_ST_IDLE;
                    end
                end
            end
        endcase
        if (state_d == NVC_ST_FETCH) begin
            addr_d = vec_base_i + {24'h0, NVC_IRQ_EXC_BASE + 6'(tgt_d), 2'b00};
        end else begin
            addr_d = frame_d + {27'h0, cnt_d, 2'b00};
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q   <= NVC_ST_IDLE;
            lvl_act_q <= '0;
            tgt_q     <= '0;
            cnt_q     <= '0;
            frame_q   <= NVC_RST_WORD;
            addr_q    <= NVC_RST_WORD;
        end else begin
            state_q   <= state_d;
            lvl_act_q <= lvl_act_d;
            tgt_q     <= tgt_d;
            cnt_q     <= cnt_d;
            frame_q   <= frame_d;
            addr_q    <= addr_d;
        end
    end

    // ------------------------------------------------------------
    // Pending requests
    // ------------------------------------------------------------
    always_comb begin
        // A request asserted in its clearing cycle stays pending
        pend_d = (pend_q & ~clr_pend) | irq_i;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pend_q <= '0;
        end else begin
            pend_q <= pend_d;
        end
    end

    // ------------------------------------------------------------
    // Core hand-off pulses and execution mode
    // ------------------------------------------------------------
    always_comb begin
        sp_load_d = 1'b0;
        sp_val_d  = sp_val_q;
        branch_d  = 1'b0;
        baddr_d   = baddr_q;
        exc_d     = exc_q;
        resume_d  = 1'b0;
        mode_d    = mode_q;
        if (push_done) begin
            sp_load_d = 1'b1;
            sp_val_d  = frame_q;
        end
        if (fetch_done) begin
            branch_d = 1'b1;
            baddr_d  = mem_rdata_i;
            exc_d    = NVC_IRQ_EXC_BASE + 6'(tgt_q);
            mode_d   = 1'b1;
        end
        if (pop_done) begin
            sp_load_d = 1'b1;
            sp_val_d  = frame_q + NVC_FRAME_BYTES;
            resume_d  = 1'b1;
            // Thread mode again only once no handler is left active
            mode_d    = |lvl_act_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sp_load_q <= 1'b0;
            sp_val_q  <= NVC_RST_WORD;
            branch_q  <= 1'b0;
            baddr_q   <= NVC_RST_WORD;
            exc_q     <= '0;
            resume_q  <= 1'b0;
            mode_q    <= 1'b0;
        end else begin
            sp_load_q <= sp_load_d;
            sp_val_q  <= sp_val_d;
            branch_q  <= branch_d;
            baddr_q   <= baddr_d;
            exc_q     <= exc_d;
            resume_q  <= resume_d;
            mode_q    <= mode_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign mem_req_o   = state_q != NVC_ST_IDLE;
    assign mem_we_o    = state_q == NVC_ST_PUSH;
    assign save_sel_o  = cnt_q;
    assign mem_wdata_o = save_word_i;
    assign rest_we_o   = (state_q == NVC_ST_POP) && mem_ack_i;
    assign rest_sel_o  = cnt_q;
    assign rest_data_o = mem_rdata_i;

    assign mem_addr_o     = addr_q;
    assign sp_load_o      = sp_load_q;
    assign sp_val_o       = sp_val_q;
    assign branch_o       = branch_q;
    assign branch_addr_o  = baddr_q;
    assign exc_num_o      = exc_q;
    assign resume_o       = resume_q;
    assign core_hold_o    = state_q != NVC_ST_IDLE;
    assign handler_mode_o = mode_q;

endmodule

// ---- logic/nvc_pkg.sv ----
// Constants and types shared by the nested vectored interrupt controller
package nvc_pkg;
    localparam int unsigned NVC_NUM_IRQ     = 32;
    localparam int unsigned NVC_IRQ_W       = 5;
    localparam int unsigned NVC_NUM_LVL     = 4;
    localparam int unsigned NVC_PRIO_W      = 2;
    localparam int unsigned NVC_LVL_W       = 3;
    localparam logic [2:0]  NVC_LVL_THREAD  = 3'h4;
    localparam int unsigned NVC_FRAME_WORDS = 8;
    localparam logic [2:0]  NVC_LAST_WORD   = 3'h7;
    localparam logic [31:0] NVC_FRAME_BYTES = 32'h0000_0020;
    localparam logic [5:0]  NVC_IRQ_EXC_BASE = 6'h10;
    localparam logic [31:0] NVC_RST_WORD    = 32'h0000_0000;

    // Frame slot order from the lowest address upward
    localparam logic [2:0]  NVC_SLOT_R0  = 3'h0;
    localparam logic [2:0]  NVC_SLOT_R1  = 3'h1;
    localparam logic [2:0]  NVC_SLOT_R2  = 3'h2;
    localparam logic [2:0]  NVC_SLOT_R3  = 3'h3;
    localparam logic [2:0]  NVC_SLOT_R12 = 3'h4;
    localparam logic [2:0]  NVC_SLOT_LNK = 3'h5;
    localparam logic [2:0]  NVC_SLOT_PC  = 3'h6;
    localparam logic [2:0]  NVC_SLOT_PSW = 3'h7;

    typedef enum logic [1:0] {
        NVC_ST_IDLE  = 2'b00,
        NVC_ST_PUSH  = 2'b01,
        NVC_ST_FETCH = 2'b10,
        NVC_ST_POP   = 2'b11
    } nvc_state_t;
endpackage

// ---- verif/nvc_core_model.sv ----
// Core register file and stack memory model
module nvc_core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        slow_i,
    input  wire logic [2:0]  save_sel_i,
    input  wire logic        mem_req_i,
    input  wire logic        mem_we_i,
    input  wire logic [31:0] mem_addr_i,
    input  wire logic [31:0] mem_wdata_i,
    input  wire logic        rest_we_i,
    input  wire logic [2:0]  rest_sel_i,
    input  wire logic [31:0] rest_data_i,
    input  wire logic        sp_load_i,
    input  wire logic [31:0] sp_val_i,
    output logic      [31:0] save_word_o,
    output logic             mem_ack_o,
    output logic      [31:0] mem_rdata_o,
    output logic      [31:0] sp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] regs [8];
    logic [31:0] stk  [64];
    logic        tog_q;
    int          wr_cnt = 0;
    assign save_word_o = regs[save_sel_i];
    assign mem_ack_o   = mem_req_i & (~slow_i | tog_q);
    assign mem_rdata_o = !mem_ack_o ? ~mem_addr_i :
                         mem_addr_i[31:16] == 16'h2000 ? stk[mem_addr_i[7:2]] :
                         mem_addr_i ^ 32'h5a5a_0000;
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tog_q <= 1'b0;
            sp_o  <= 32'h2000_0100;
            for (int s = 0; s < 8; s++) begin
                regs[s] <= 32'h1000_0000 + 32'(s);
            end
        end else begin
            tog_q <= mem_req_i & ~tog_q;
            if (mem_ack_o && mem_we_i) begin
                stk[mem_addr_i[7:2]] <= mem_wdata_i;
                wr_cnt <= wr_cnt + 1;
            end
            if (rest_we_i) begin
                regs[rest_sel_i] <= rest_data_i;
            end
            if (sp_load_i) begin
                sp_o <= sp_val_i;
            end
            // A handler clobbers the core registers once its frame is saved
            if (sp_load_i && sp_val_i < sp_o) begin
                for (int s = 0; s < 8; s++) begin
                    regs[s] <= ~regs[s];
                end
            end
        end
    end
endmodule

// ---- verif/nvc_ctrl_sva.sv ----
// Port assertions for the interrupt controller
module nvc_ctrl_sva (
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic [31:0] irq_i,
    input wire logic        exc_return_i,
    input wire logic [31:0] save_word_i,
    input wire logic        mem_req_o,
    input wire logic        mem_we_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic [31:0] mem_wdata_o,
    input wire logic        mem_ack_i,
    input wire logic [31:0] mem_rdata_i,
    input wire logic        rest_we_o,
    input wire logic [31:0] rest_data_o,
    input wire logic        sp_load_o,
    input wire logic [31:0] sp_val_o,
    input wire logic        branch_o,
    input wire logic        resume_o,
    input wire logic        core_hold_o,
    input wire logic        handler_mode_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_reset_thread: assert property ($rose(rst_b_i) |-> !handler_mode_o && !core_hold_o)
        else $error("not in thread mode after reset");
    a_branch_mode: assert property (branch_o |=> handler_mode_o)
        else $error("handler mode missing after entry");
    a_thread_ret: assert property (exc_return_i && !handler_mode_o && !core_hold_o
        && !$past(core_hold_o) && irq_i == '0 && $past(irq_i) == '0 |=> !resume_o && !mem_req_o)
        else $error("return acted in thread mode");
    a_branch_ack: assert property (branch_o |-> $past(mem_req_o && !mem_we_o && mem_ack_i))
        else $error("branch without vector read");
    a_push_data: assert property (mem_req_o && mem_we_o |-> mem_wdata_o == save_word_i)
        else $error("pushed word differs");
    a_push_sp: assert property (sp_load_o && $past(mem_we_o)
        |-> sp_val_o == $past(mem_addr_o) - 32'h1c)
        else $error("stack pointer after push wrong");
    a_pop_sp: assert property (resume_o |-> sp_load_o
        && sp_val_o == $past(mem_addr_o) + 32'h4)
        else $error("stack pointer after pop wrong");
    a_rest_data: assert property (rest_we_o |-> mem_ack_i && !mem_we_o
        && rest_data_o == mem_rdata_i)
        else $error("restore word differs");
    a_mode_drop: assert property ($fell(handler_mode_o) |-> resume_o)
        else $error("handler mode left without a restore");
    a_hold_mem: assert property (mem_req_o |-> core_hold_o)
        else $error("memory access while core runs");
endmodule

bind nvc_ctrl nvc_ctrl_sva nvc_ctrl_sva_inst (.clk_i, .rst_b_i, .irq_i, .exc_return_i,
    .save_word_i, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i,
    .mem_rdata_i, .rest_we_o, .rest_data_o, .sp_load_o, .sp_val_o, .branch_o, .resume_o,
    .core_hold_o, .handler_mode_o);

// ---- verif/tb_top.sv ----
// Testbench for the interrupt controller
module tb_top
    import nvc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] SP0 = 32'h2000_0100;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        exc_return_i = 1'b0;
    logic        slow = 1'b0;
    logic [31:0] irq_i = '0;
    logic [63:0] irq_prio_i = '1;
    logic [31:0] vec_base_i = 32'h0000_1000;
    logic [31:0] sp_i, save_word_i, mem_addr_o, mem_wdata_o, mem_rdata_i;
    logic [31:0] rest_data_o, sp_val_o, branch_addr_o;
    logic [2:0]  save_sel_o, rest_sel_o;
    logic [5:0]  exc_num_o;
    logic        mem_req_o, mem_we_o, mem_ack_i, rest_we_o, sp_load_o;
    logic        branch_o, resume_o, core_hold_o, handler_mode_o;
    int          miscompares = 0;
    int          checked = 0;
    int          cycles = 0;
    nvc_ctrl nvc_ctrl_inst (.clk_i, .rst_b_i, .irq_i, .irq_prio_i, .exc_return_i, .sp_i,
        .vec_base_i, .save_word_i, .save_sel_o, .mem_req_o, .mem_we_o, .mem_addr_o,
        .mem_wdata_o, .mem_ack_i, .mem_rdata_i, .rest_we_o, .rest_sel_o, .rest_data_o,
        .sp_load_o, .sp_val_o, .branch_o, .branch_addr_o, .exc_num_o, .resume_o,
        .core_hold_o, .handler_mode_o);
    nvc_core_model nvc_core_model_inst (.clk_i, .rst_b_i, .slow_i(slow), .save_sel_i(save_sel_o),
        .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .rest_we_i(rest_we_o), .rest_sel_i(rest_sel_o),
        .rest_data_i(rest_data_o), .sp_load_i(sp_load_o), .sp_val_i(sp_val_o),
        .save_word_o(save_word_i), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i), .sp_o(sp_i));
    initial forever #12.5 clk_i = ~clk_i;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    task automatic fire(int k, logic [1:0] p);
        irq_prio_i[2*k+:2] = p;
        irq_i[k] = 1'b1;
        step(1);
        irq_i[k] = 1'b0;
    endtask
    task automatic ret();
        exc_return_i = 1'b1;
        step(1);
        exc_return_i = 1'b0;
    endtask
    task automatic wait_br(logic [5:0] exc);
        for (int i = 0; i < 300 && branch_o !== 1'b1; i++) step(1);
        chk("branch", branch_o, 1'b1);
        chk("exc_num", exc_num_o, exc);
        chk("vector", branch_addr_o, (vec_base_i + (32'(exc) << 2)) ^ 32'h5a5a_0000);
        step(1);
        chk("handler", handler_mode_o, 1'b1);
    endtask
    task automatic wait_res(logic [31:0] sp_exp);
        for (int i = 0; i < 300 && resume_o !== 1'b1; i++) step(1);
        chk("resume", resume_o, 1'b1);
        step(1);
        chk("sp_pop", sp_i, sp_exp);
    endtask
    task automatic wrap_up();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_entry();
        fire(5, 2'h2);
        wait_br(6'h15);
        chk("sp_push", sp_i, SP0 - 32'h20);
        for (int s = 0; s < 8; s++) begin
            chk("frame", nvc_core_model_inst.stk[56+s], 32'h1000_0000 + s);
        end
        $display("entry done");
    endtask
    task automatic t_nest();
        fire(9, 2'h2);
        step(20);
        chk("equal_wait", core_hold_o, 1'b0);
        chk("still_21", exc_num_o, 6'h15);
        fire(3, 2'h1);
        wait_br(6'h13);
        chk("sp_nest", sp_i, SP0 - 32'h40);
        $display("nest done");
    endtask
    task automatic t_unwind();
        int w;
        ret();
        wait_res(SP0 - 32'h20);
        for (int s = 0; s < 8; s++) begin
            chk("rest_nest", nvc_core_model_inst.regs[s], ~(32'h1000_0000 + s));
        end
        w = nvc_core_model_inst.wr_cnt;
        ret();
        wait_br(6'h19);
        chk("chain_push", nvc_core_model_inst.wr_cnt, w);
        chk("chain_sp", sp_i, SP0 - 32'h20);
        ret();
        wait_res(SP0);
        chk("thread", handler_mode_o, 1'b0);
        for (int s = 0; s < 8; s++) begin
            chk("rest_top", nvc_core_model_inst.regs[s], 32'h1000_0000 + s);
        end
        $display("unwind done");
    endtask
    task automatic t_thread_ret();
        ret();
        step(3);
        chk("no_hold", core_hold_o, 1'b0);
        chk("no_pop", sp_i, SP0);
        $display("thread return done");
    endtask
    task automatic t_late();
        int w;
        slow = 1'b1;
        w = nvc_core_model_inst.wr_cnt;
        fire(12, 2'h3);
        step(4);
        fire(2, 2'h0);
        wait_br(6'h12);
        chk("late_push", nvc_core_model_inst.wr_cnt, w + 8);
        ret();
        wait_br(6'h1c);
        ret();
        wait_res(SP0);
        slow = 1'b0;
        $display("late arrival done");
    endtask
    task automatic t_tie();
        irq_prio_i[15:14] = 2'h1;
        irq_prio_i[9:8] = 2'h1;
        irq_i = 32'h0000_0090;
        step(1);
        irq_i = '0;
        wait_br(6'h14);
        ret();
        wait_br(6'h17);
        ret();
        wait_res(SP0);
        $display("tie done");
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        step(12);
        rst_b_i = 1'b1;
        step(2);
        chk("reset_mode", handler_mode_o, 1'b0);
        t_entry();
        t_nest();
        t_unwind();
        t_thread_ret();
        t_late();
        t_tie();
        wrap_up();
    end
endmodule
